//--- verilog/rss_top.v
// Reset source sequencer: combines five reset sources into the internal reset
// Behaviour
// - Reset clears registers, ports; fetch from 0000H
// - Five sources request the internal reset
// - Power-on: 143 us init, then start-up delay
// - Start-up timer waits for brown-out clear
// - Power-on detector low reasserts reset instantly
// - Cold reset sets power-off flag
// - Active reset pin extends reset past time-out
// - Fuses and clock type select start-up delay
// - Same delay after brown-out and timed wake
// - Brown-out low asserts reset immediately
// - Brown-out recovery waits full start-up delay
// - Polarity pin selects reset pin sense
// - Compatibility: sample every six, need twelve
// - Fast: sample every clock, need two
// - Active pin enables serial programming entry
// - Watchdog time-out gives 49-clock pulse
// - Pulse drives pin unless output disabled
// - Watchdog reset sets overflow flag
// - 5AH, A5H gives pulse and software flag
// - Bad pair resets, sets both flags
// - Software reset drives pin unless disabled
// - Power-off flag writable, kept over warm reset
`timescale 1ns/1ps
module rss_top
(
  // Clock and logic reset
  input  wire        i_mclk,
  input  wire        i_srst,
  // Analog comparator levels (high = supply above trip level)
  input  wire        i_por_ok,
  input  wire        i_bod_ok,
  // Reset pin, polarity strap, pin driver
  input  wire        i_rst_pin,
  input  wire        i_reset_polarity_select,
  output reg         o_rst_pin_out,
  output reg         o_rst_pin_oe,
  output reg         o_rst_pin_pullup,
  output reg         o_rst_pin_pulldown,
  // Fuses and configuration
  input  wire [1:0]  i_startup_time_fuse,
  input  wire        i_crystal_clock,
  input  wire        i_compat_mode,
  input  wire        i_isp_fuse_enable,
  input  wire        i_reset_output_disable_aux,
  input  wire        i_reset_output_disable_wdc,
  // Timed wake request from power-down
  input  wire        i_wake_timed,
  // Watchdog time-out and restart register write
  input  wire        i_wdt_timeout,
  input  wire        i_restart_wr,
  input  wire [7:0]  i_restart_data,
  // Power-off flag software write
  input  wire        i_power_off_flag_wr,
  input  wire        i_power_off_flag_wdata,
  // Status flags and reset outputs
  output reg         o_power_off_flag,
  output reg         o_watchdog_overflow_flag,
  output reg         o_software_reset_flag,
  output reg         o_watchdog_restart,
  output reg         o_internal_reset,
  output reg         o_cpu_hold,
  output reg [15:0]  o_reset_vector,
  output reg         o_serial_programming_entry
);
`include "rss_regs.vh"

  localparam ST_OFF   = 2'h0;
  localparam ST_INIT  = 2'h1;
  localparam ST_SUT   = 2'h2;
  localparam ST_RUN   = 2'h3;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [22:0] count;
  reg  [5:0]  pulse_cnt;
  reg         have_first;
  reg  [7:0]  first_byte;
  reg         wake_run;
  reg         powered;
  wire        pin_active;
  wire        pin_reset;
  wire        rst_out_disable;
  wire [22:0] sut_cyc;
  wire        pair_done;
  wire        is_restart;
  wire        is_swreset;
  wire        any_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up delay in clocks for a fuse code and clock type
  function [22:0] rss_sut_cycles;
    input [1:0] fuse;
    input       xtal;
    reg   [14:0] us;
    reg   [31:0] prod;
    begin
      us = 15'h0;
      case ({xtal, fuse})
        3'h0:    us = `RSS_SUT_RC0_US;
        3'h1:    us = `RSS_SUT_RC1_US;
        3'h2:    us = `RSS_SUT_RC2_US;
        3'h3:    us = `RSS_SUT_RC3_US;
        3'h4:    us = `RSS_SUT_XT0_US;
        3'h5:    us = `RSS_SUT_XT1_US;
        3'h6:    us = `RSS_SUT_XT2_US;
        default: us = `RSS_SUT_XT3_US;
      endcase
      prod           = us * `RSS_CYC_PER_US;
      rss_sut_cycles = prod[22:0];
    end
  endfunction

  assign sut_cyc = rss_sut_cycles(i_startup_time_fuse, i_crystal_clock);

  assign pin_active = i_reset_polarity_select ? i_rst_pin : ~i_rst_pin;

  assign rst_out_disable = i_compat_mode ? i_reset_output_disable_aux
                                         : i_reset_output_disable_wdc;

  ////////////////////////////////////////////////////////////////////////////
  // Pin filter, sampling rate follows the mode
  rss_pin_filter u_pin_filter
  (
    .i_mclk        (i_mclk),
    .i_srst        (i_srst),
    .i_pin_active  (pin_active),
    .i_compat_mode (i_compat_mode),
    .o_pin_reset   (pin_reset)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power sequence next state; comparator drops win over any count, except that a brown-out drop leaves the init count running
  always @*
  begin
    next_state = state;
    case (state)
      ST_OFF:
        if (i_por_ok)
          next_state = ST_INIT;
      ST_INIT:
        if (count >= (`RSS_INIT_CYC - 1))
          next_state = ST_SUT;
      ST_SUT:
        // wait for brown-out clear and full delay
        if (i_bod_ok && count >= sut_cyc - 23'h1)
          next_state = ST_RUN;
      ST_RUN:
        if (!i_bod_ok)
          next_state = ST_SUT;
      default:
        next_state = ST_OFF;
    endcase
    if (!i_por_ok)
      next_state = ST_OFF;
  end

  // Sequence state and its counter; count restarts on every state change
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      state <= ST_OFF;
      count <= 23'h0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state || (state == ST_SUT && !i_bod_ok) ||
          (state == ST_RUN && i_wake_timed && !wake_run))
        count <= 23'h0;
      else if (state != ST_RUN || wake_run)
        count <= count + 23'h1;
    end
  end

  // timed wake holds the CPU clock for the start-up delay
  always @(posedge i_mclk)
  begin
    if (i_srst || state != ST_RUN)
    begin
      wake_run <= 1'b0;
    end
    else if (i_wake_timed && !wake_run)
      wake_run <= 1'b1;
    else if (wake_run && count >= sut_cyc - 23'h1)
      wake_run <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart register pair decode; second write completes a pair
  assign pair_done  = i_restart_wr && have_first;
  assign is_restart = (first_byte == `RSS_RESTART_B1) && (i_restart_data == `RSS_RESTART_B2);
  assign is_swreset = (first_byte == `RSS_SWRESET_B1) && (i_restart_data == `RSS_SWRESET_B2);

  always @(posedge i_mclk)
  begin
    if (i_srst || o_internal_reset)
    begin
      have_first         <= 1'b0;
      first_byte         <= 8'h00;
      o_watchdog_restart <= 1'b0;
    end
    else
    begin
      // restart pair passed to the watchdog counter
      o_watchdog_restart <= pair_done && is_restart;
      if (i_restart_wr)
      begin
        have_first <= ~have_first;
        first_byte <= i_restart_data;
      end
    end
  end

  // pulse counter for watchdog and software resets
  always @(posedge i_mclk)
  begin
    if (i_srst)
      pulse_cnt <= 6'h0;
    else if (i_wdt_timeout || (pair_done && !is_restart))
      pulse_cnt <= `RSS_PULSE_CYC;
    else if (pulse_cnt != 6'h0)
      pulse_cnt <= pulse_cnt - 6'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: cold power-up, watchdog time-out and pairs other than 1EH, E1H set them; only power-off is software-writable
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_power_off_flag         <= 1'b0;
      o_watchdog_overflow_flag <= 1'b0;
      o_software_reset_flag    <= 1'b0;
    end
    else
    begin
      // cold reset sets, software writes, warm reset keeps
      if (state == ST_OFF)
        o_power_off_flag <= 1'b1;
      else if (i_power_off_flag_wr)
        o_power_off_flag <= i_power_off_flag_wdata;
      if (i_wdt_timeout || (pair_done && !is_restart && !is_swreset))
        o_watchdog_overflow_flag <= 1'b1;
      if (pair_done && !is_restart)
        o_software_reset_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered OR of all sources
  // comparators bypass sequencer, so a drop never sees a free cycle
  assign any_reset = (state != ST_RUN) || !i_por_ok || !i_bod_ok || pin_reset ||
                     (pulse_cnt != 6'h0);

  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      powered                    <= 1'b0;
      o_internal_reset           <= 1'b1;
      o_cpu_hold                 <= 1'b1;
      o_reset_vector             <= `RSS_RESET_VECTOR;
      o_rst_pin_out              <= 1'b0;
      o_rst_pin_oe               <= 1'b0;
      o_rst_pin_pullup           <= 1'b0;
      o_rst_pin_pulldown         <= 1'b0;
      o_serial_programming_entry <= 1'b0;
    end
    else
    begin
      o_internal_reset <= any_reset;
      // clock held while the timed wake runs its delay
      o_cpu_hold       <= any_reset || wake_run;
      // fetch restarts at the reset vector
      o_reset_vector   <= `RSS_RESET_VECTOR;
      o_rst_pin_pullup   <= ~i_reset_polarity_select;
      o_rst_pin_pulldown <= i_reset_polarity_select;
      // pulse drives the pin at its active level
      o_rst_pin_oe  <= (pulse_cnt != 6'h0) && !rst_out_disable;
      o_rst_pin_out <= i_reset_polarity_select;
      // entry while pin active; fuse disables it only after power-up
      if (state == ST_RUN)
        powered <= 1'b1;
      else if (state == ST_OFF)
        powered <= 1'b0;
      o_serial_programming_entry <= pin_reset &&
                                    (i_isp_fuse_enable || !powered ||
                                     o_serial_programming_entry);
    end
  end
endmodule

//--- verilog/rss_regs.vh
// Constants for the reset source sequencer
`ifndef RSS_REGS_VH
`define RSS_REGS_VH
// Clock rate in kHz (250 MHz)
`define RSS_CLK_KHZ          250000
// Initialization phase after power-on, in ns
`define RSS_INIT_PHASE_NS    143000
`define RSS_INIT_CYC         ((`RSS_INIT_PHASE_NS * (`RSS_CLK_KHZ / 1000) + 999) / 1000)
// Start-up delays in us, RC/external clock then crystal, fuse codes 00..11
`define RSS_SUT_RC0_US       15'h0010
`define RSS_SUT_RC1_US       15'h0200
`define RSS_SUT_RC2_US       15'h0400
`define RSS_SUT_RC3_US       15'h1000
`define RSS_SUT_XT0_US       15'h0400
`define RSS_SUT_XT1_US       15'h0800
`define RSS_SUT_XT2_US       15'h1000
`define RSS_SUT_XT3_US       15'h4000
`define RSS_CYC_PER_US       (`RSS_CLK_KHZ / 1000)
// Watchdog and software reset pulse length in clocks
`define RSS_PULSE_CYC        6'h31
// Compatibility mode sampling interval and samples to trigger
`define RSS_COMPAT_DIV       3'h6
`define RSS_COMPAT_SAMPLES   2'h2
`define RSS_FAST_SAMPLES     2'h2
// Restart register byte codes
`define RSS_RESTART_B1       8'h1e
`define RSS_RESTART_B2       8'he1
`define RSS_SWRESET_B1       8'h5a
`define RSS_SWRESET_B2       8'ha5
// Reset vector
`define RSS_RESET_VECTOR     16'h0000
`endif

//--- verilog/rss_pin_filter.v
// Reset pin sampler with mode-dependent sampling rate and hold filter
`timescale 1ns/1ps
module rss_pin_filter
(
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_srst,
  // Pin and mode
  input  wire       i_pin_active,
  input  wire       i_compat_mode,
  // Filtered level
  output reg        o_pin_reset
);
`include "rss_regs.vh"

  reg [2:0] div;
  reg [1:0] hits;
  wire      sample_en;
  wire [1:0] need;

  assign sample_en = i_compat_mode ? (div == 3'h0) : 1'b1;
  assign need      = i_compat_mode ? `RSS_COMPAT_SAMPLES : `RSS_FAST_SAMPLES;

  ////////////////////////////////////////////////////////////////////////////
  // Divider gives one sample enable every six clocks in compatibility mode
  always @(posedge i_mclk)
  begin
    if (i_srst || !i_compat_mode || div == (`RSS_COMPAT_DIV - 3'h1))
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end

  // sample and hold
  // Two consecutive active samples assert; one inactive sample releases
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      hits        <= 2'h0;
      o_pin_reset <= 1'b0;
    end
    else if (sample_en)
    begin
      if (!i_pin_active)
      begin
        hits        <= 2'h0;
        o_pin_reset <= 1'b0;
      end
      else if (hits + 2'h1 >= need)
      begin
        hits        <= need;
        o_pin_reset <= 1'b1;
      end
      else
        hits <= hits + 2'h1;
    end
  end
endmodule

//--- verification/rss_board.sv
// Board-side model: resolves the shared reset pin
`timescale 1ns/1ps
module rss_board
(
  // Board request and polarity strap
  input  wire i_pol,
  input  wire i_hold,
  // Device pin driver
  input  wire i_dev_oe,
  input  wire i_dev_out,
  // Resolved pin level
  output wire o_pin
);
  // board hold wins, else device drive, else pull level
  assign o_pin = i_hold ? i_pol : (i_dev_oe ? i_dev_out : !i_pol);
endmodule

//--- verification/rss_checker_asserts.sv
// Concurrent checks on the reset source sequencer ports
`timescale 1ns/1ps
module rss_checker
(
  // Watched ports
  input wire        i_mclk,
  input wire        i_srst,
  input wire        i_por_ok,
  input wire        i_bod_ok,
  input wire        i_reset_polarity_select,
  input wire        i_compat_mode,
  input wire        i_reset_output_disable_aux,
  input wire        i_reset_output_disable_wdc,
  input wire        i_wdt_timeout,
  input wire        o_rst_pin_oe,
  input wire        o_rst_pin_pullup,
  input wire        o_rst_pin_pulldown,
  input wire        o_watchdog_overflow_flag,
  input wire        o_watchdog_restart,
  input wire        o_internal_reset,
  input wire [15:0] o_reset_vector
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  reg [7:0] oe_cnt = 8'h00;
  // Length of the current pin drive, pulse length needs more than 8 cycles
  always @(posedge i_mclk)
  begin
    if (o_rst_pin_oe)
      oe_cnt <= oe_cnt + 8'h01;
    else
      oe_cnt <= 8'h00;
  end
  sequence s_wdt_fire;
    i_wdt_timeout && !o_internal_reset;
  endsequence
  sequence s_wdt_pulse;
    ##2 o_internal_reset;
  endsequence
  property p_srst;
    disable iff (1'b0) i_srst |=> o_internal_reset && !o_rst_pin_oe;
  endproperty
  a_srst: assert property (p_srst) else $error("reset not held");
  property p_vector;
    o_reset_vector == 16'h0000;
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");
  property p_wdt_pulse;
    s_wdt_fire |-> s_wdt_pulse;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("no pulse");
  property p_wdt_flag;
    s_wdt_fire |=> o_watchdog_overflow_flag;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("no overflow flag");
  property p_oe_len;
    $fell(o_rst_pin_oe) |-> oe_cnt >= 8'h31 && oe_cnt <= 8'h32;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("pin pulse length");
  property p_oe_gate;
    $rose(o_rst_pin_oe) |->
      !$past(i_compat_mode ? i_reset_output_disable_aux : i_reset_output_disable_wdc);
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("drive while disabled");
  property p_bod;
    !i_bod_ok |-> ##[1:2] o_internal_reset;
  endproperty
  a_bod: assert property (p_bod) else $error("brown-out ignored");
  property p_por;
    !i_por_ok |-> ##[1:2] o_internal_reset;
  endproperty
  a_por: assert property (p_por) else $error("power-on ignored");
  property p_release;
    $fell(o_internal_reset) |-> $past(i_por_ok) && $past(i_bod_ok);
  endproperty
  a_release: assert property (p_release) else $error("early release");
  property p_pulls;
    !$past(i_srst) && $stable(i_reset_polarity_select) |->
      o_rst_pin_pulldown == i_reset_polarity_select &&
      o_rst_pin_pullup == !i_reset_polarity_select;
  endproperty
  a_pulls: assert property (p_pulls) else $error("pull mismatch");
  property p_restart;
    o_watchdog_restart |=> !o_watchdog_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("restart too long");
endmodule
bind rss_top rss_checker chk_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_por_ok(i_por_ok),
  .i_bod_ok(i_bod_ok), .i_reset_polarity_select(i_reset_polarity_select),
  .i_compat_mode(i_compat_mode), .i_reset_output_disable_aux(i_reset_output_disable_aux),
  .i_reset_output_disable_wdc(i_reset_output_disable_wdc), .i_wdt_timeout(i_wdt_timeout),
  .o_rst_pin_oe(o_rst_pin_oe), .o_rst_pin_pullup(o_rst_pin_pullup),
  .o_rst_pin_pulldown(o_rst_pin_pulldown), .o_reset_vector(o_reset_vector),
  .o_watchdog_overflow_flag(o_watchdog_overflow_flag),
  .o_watchdog_restart(o_watchdog_restart), .o_internal_reset(o_internal_reset));

//--- verification/rss_top_bench.sv
// Self-checking bench for the reset source sequencer
`timescale 1ns/1ps
module rss_top_bench;
  reg mclk = 1'b0;
  reg srst = 1'b1;
  reg por_ok = 1'b0;
  reg bod_ok = 1'b0;
  reg reset_polarity_select = 1'b1;
  reg hold = 1'b0;
  reg compat = 1'b0;
  reg dis_aux = 1'b0;
  reg dis_wdc = 1'b1;
  reg wdt_to = 1'b0;
  reg rwr = 1'b0;
  reg [7:0] rdata = 8'h00;
  reg pof_wr = 1'b0;
  reg wake = 1'b0;
  reg isp_en = 1'b1;
  wire cpu_hold;
  reg chk = 1'b0;
  reg [7:0] b;
  wire pin, pin_out, pin_oe, power_off_flag, ovf, swf, wrst, irst, serial_programming_entry;
  reg [3:0] exp_q[$];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n_wrst = 0;
  int n_oe = 0;
  int n;
  int k;
  always #2 mclk = ~mclk;
  rss_board brd_u (.i_pol(reset_polarity_select), .i_hold(hold), .i_dev_oe(pin_oe), .i_dev_out(pin_out),
    .o_pin(pin));
  rss_top dut_u (.i_mclk(mclk), .i_srst(srst), .i_por_ok(por_ok), .i_bod_ok(bod_ok),
    .i_rst_pin(pin), .i_reset_polarity_select(reset_polarity_select), .o_rst_pin_out(pin_out),
    .o_rst_pin_oe(pin_oe), .o_rst_pin_pullup(), .o_rst_pin_pulldown(),
    .i_startup_time_fuse(2'h0), .i_crystal_clock(1'b0), .i_compat_mode(compat),
    .i_isp_fuse_enable(isp_en), .i_reset_output_disable_aux(dis_aux),
    .i_reset_output_disable_wdc(dis_wdc), .i_wake_timed(wake), .i_wdt_timeout(wdt_to),
    .i_restart_wr(rwr), .i_restart_data(rdata), .i_power_off_flag_wr(pof_wr),
    .i_power_off_flag_wdata(1'b0), .o_power_off_flag(power_off_flag), .o_watchdog_overflow_flag(ovf),
    .o_software_reset_flag(swf), .o_watchdog_restart(wrst), .o_internal_reset(irst),
    .o_cpu_hold(cpu_hold), .o_reset_vector(), .o_serial_programming_entry(serial_programming_entry));
  task give_verdict();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input bit ok, input string msg);
    check_count++;
    if (!ok)
    begin
      errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watcher: compares the oldest note with {reset, power-off, overflow, software}
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (wrst === 1'b1)
      n_wrst <= n_wrst + 1;
    if (pin_oe === 1'b1)
      n_oe <= n_oe + 1;
    if (chk)
      check({irst, power_off_flag, ovf, swf} === exp_q.pop_front(), "status mismatch");
    // Cut a hang short well beyond the longest expected run
    if (cyc == 90000)
    begin
      errors++;
      give_verdict();
    end
  end
  task expect_st(input [3:0] e);
    exp_q.push_back(e);
    chk <= 1'b1;
    @(posedge mclk);
    chk <= 1'b0;
    @(posedge mclk);
  endtask
  task wr_pair(input [7:0] a, input [7:0] c);
    rwr <= 1'b1;
    rdata <= a;
    @(posedge mclk);
    rdata <= c;
    @(posedge mclk);
    rwr <= 1'b0;
    @(posedge mclk);
  endtask
  task wait_hi(input int lim);
    n = 0;
    while (irst !== 1'b1 && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
    check(irst === 1'b1, "reset not raised");
  endtask
  task wait_rel(input int lim);
    n = 0;
    while (irst !== 1'b0 && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
    check(irst === 1'b0, "reset not released");
  endtask
  task pin_pulse(input int w);
    hold <= 1'b1;
    repeat (w) @(posedge mclk);
    hold <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; power-up is long, so it is done only once
  initial
  begin
    void'($urandom(32'h1c042a18));
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    por_ok <= 1'b1;
    repeat (36000) @(posedge mclk);
    check(irst === 1'b1, "released before brown-out clear");
    bod_ok <= 1'b1;
    wait_rel(4100);
    check(n >= 4000 && n <= 4010, "start-up delay");
    expect_st(4'b0100);
    pof_wr <= 1'b1;
    @(posedge mclk);
    pof_wr <= 1'b0;
    expect_st(4'b0000);
    k = n_wrst;
    wr_pair(8'h1e, 8'he1);
    repeat (4) @(posedge mclk);
    check(n_wrst == k + 1, "no restart");
    expect_st(4'b0000);
    k = n_oe;
    wr_pair(8'h5a, 8'ha5);
    wait_hi(6);
    wait_rel(100);
    check(n >= 47 && n <= 51, "pulse length");
    check(n_oe == k, "pin driven while disabled");
    expect_st(4'b0001);
    dis_wdc <= 1'b0;
    b = $urandom;
    while (b == 8'h1e || b == 8'h5a)
      b = $urandom;
    wr_pair(b, $urandom);
    wait_hi(6);
    wait_rel(6000);
    expect_st(4'b0011);
    k = n_oe;
    wdt_to <= 1'b1;
    @(posedge mclk);
    wdt_to <= 1'b0;
    wait_hi(4);
    wait_rel(6000);
    check(n_oe > k, "pin not driven");
    pin_pulse(1);
    repeat (8) @(posedge mclk);
    expect_st(4'b0011);
    pin_pulse(2);
    wait_hi(6);
    wait_rel(6000);
    compat <= 1'b1;
    dis_aux <= 1'b1;
    reset_polarity_select <= 1'b0;
    repeat (4) @(posedge mclk);
    pin_pulse(5);
    repeat (14) @(posedge mclk);
    expect_st(4'b0011);
    hold <= 1'b1;
    repeat (200) @(posedge mclk);
    check(irst === 1'b1, "pin did not hold reset");
    check(serial_programming_entry === 1'b1, "no programming entry");
    hold <= 1'b0;
    wait_rel(6000);
    // Fuse off after power-up: the pin resets but gives no programming entry
    isp_en <= 1'b0;
    hold <= 1'b1;
    repeat (200) @(posedge mclk);
    check(serial_programming_entry === 1'b0 && irst === 1'b1, "programming entry with fuse off");
    hold <= 1'b0;
    wait_rel(6000);
    bod_ok <= 1'b0;
    wait_hi(3);
    bod_ok <= 1'b1;
    wait_rel(4100);
    check(n >= 4000 && n <= 4010, "brown-out delay");
    expect_st(4'b0011);
    // Timed wake holds the CPU for the start-up delay, no internal reset
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    repeat (2) @(posedge mclk);
    check(cpu_hold === 1'b1 && irst === 1'b0, "timed wake not held");
    n = 0;
    while (cpu_hold !== 1'b0 && n < 4100)
    begin
      @(posedge mclk);
      n++;
    end
    check(n >= 3990 && n <= 4010, "timed wake delay");
    give_verdict();
  end
endmodule
